//--- supply_voltage_detect_control.sv
`timescale 1ns/1ps
`default_nettype none
module supply_voltage_detect_control #(
   parameter int STARTUP_CYCLES = svd_pkg::STARTUP_CYCLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // analog front end
   input wire logic comp_above,
   input wire logic shared_ref_on,
   output logic detector_power_on,
   output logic [3:0] tap_select,
   output logic external_trip_select,
   // core power and interrupt
   input wire logic sleep_active,
   output logic irq,
   output logic wake_request,
   output logic vector_take
);
   // ==========================================================
   // state
   svd_pkg::control_t ctrl;
   logic detect_flag;
   logic detect_ie;
   logic detect_ip;
   logic global_ie;
   logic periph_ie;
   logic shared_q;
   logic [svd_pkg::SETTLE_W-1:0] settle_cnt;

   localparam logic [svd_pkg::SETTLE_W-1:0] SETTLE_LAST = svd_pkg::SETTLE_W'(STARTUP_CYCLES - 1);

   // ==========================================================
   // bus decode
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr = req & wb_we_i & wb_sel_i[0];
   wire [7:0] wbyte = wb_dat_i[7:0];
   svd_pkg::control_t wctrl;
   assign wctrl = svd_pkg::control_t'(wbyte);
   wire hit_ctrl = wb_adr_i == svd_pkg::ADDR_CONTROL;
   wire hit_flags = wb_adr_i == svd_pkg::ADDR_FLAGS;
   wire hit_clear = wb_adr_i == svd_pkg::ADDR_FLAG_CLEAR;
   wire hit_en = wb_adr_i == svd_pkg::ADDR_ENABLES;
   wire hit_pri = wb_adr_i == svd_pkg::ADDR_PRIORITY;
   wire hit_int = wb_adr_i == svd_pkg::ADDR_INT_CONTROL;

   wire wr_ctrl = wr & hit_ctrl;
   wire wr_clear = wr & hit_clear & wbyte[svd_pkg::BIT_DETECT];
   wire wr_en = wr & hit_en;
   wire wr_pri = wr & hit_pri;
   wire wr_int = wr & hit_int;

   // ==========================================================
   // start-up interval
   wire shared_rise = shared_ref_on & ~shared_q;
   // reference wakes from off, or detector is off: start over
   wire settle_restart = ~ctrl.en | shared_rise;
   wire settle_done = settle_cnt == SETTLE_LAST;
   wire [svd_pkg::SETTLE_W-1:0] next_settle_cnt =
      settle_restart ? '0 : (settle_done ? settle_cnt : settle_cnt + 1'b1);
   wire next_stable = ~settle_restart & settle_done;

   // ==========================================================
   // control register
   // stable bit is owned by hardware; writes to it and bit 6 are dropped
   wire [7:0] ctrl_read = {ctrl.dir, 1'b0, ctrl.stable, ctrl.en, ctrl.level};
   wire next_dir = wr_ctrl ? wctrl.dir : ctrl.dir;
   wire next_en = wr_ctrl ? wctrl.en : ctrl.en;
   wire [3:0] next_level = wr_ctrl ? wctrl.level : ctrl.level;

   // ==========================================================
   // detection
   // comparator answers against the selected tap, or the pin for 1111
   wire crossing = ctrl.dir ? comp_above : ~comp_above;
   wire detect_event = ctrl.en & ctrl.stable & crossing;
   // set beats a clear in the same cycle
   wire next_flag = detect_event | (detect_flag & ~wr_clear);

   // ==========================================================
   // interrupt and wake
   wire next_irq = detect_flag & detect_ie & global_ie;
   // wake needs only the local enable; sleep is left either way
   wire next_wake = sleep_active & detect_flag & detect_ie;
   wire next_vector = next_wake & global_ie;
   wire next_ext = ctrl.level == svd_pkg::LEVEL_EXTERNAL;

   // ==========================================================
   // read mux
   wire [7:0] flags_read = 8'(detect_flag) << svd_pkg::BIT_DETECT;
   wire [7:0] en_read = 8'(detect_ie) << svd_pkg::BIT_DETECT;
   wire [7:0] pri_read = 8'(detect_ip) << svd_pkg::BIT_DETECT;
   wire [7:0] int_read = (8'(global_ie) << svd_pkg::BIT_GLOBAL) | (8'(periph_ie) << svd_pkg::BIT_PERIPH);
   wire [7:0] rbyte =
      hit_ctrl ? ctrl_read :
      hit_flags ? flags_read :
      hit_en ? en_read :
      hit_pri ? pri_read :
      hit_int ? int_read : svd_pkg::RESET_BYTE;
   wire [31:0] next_rdata = wb_we_i ? svd_pkg::READ_ZERO : {24'h000000, rbyte};

   // ==========================================================
   // flip-flops
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= svd_pkg::CONTROL_RESET;
         settle_cnt <= '0;
         shared_q <= 1'b0;
         detect_flag <= 1'b0;
      end else begin
         ctrl <= '{dir: next_dir, unused6: 1'b0, stable: next_stable, en: next_en, level: next_level};
         settle_cnt <= next_settle_cnt;
         shared_q <= shared_ref_on;
         detect_flag <= next_flag;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         detect_ie <= 1'b0;
         detect_ip <= 1'b0;
         global_ie <= 1'b0;
         periph_ie <= 1'b0;
      end else begin
         if (wr_en) begin
            detect_ie <= wbyte[svd_pkg::BIT_DETECT];
         end
         if (wr_pri) begin
            detect_ip <= wbyte[svd_pkg::BIT_DETECT];
         end
         if (wr_int) begin
            global_ie <= wbyte[svd_pkg::BIT_GLOBAL];
            periph_ie <= wbyte[svd_pkg::BIT_PERIPH];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= svd_pkg::READ_ZERO;
         irq <= 1'b0;
         wake_request <= 1'b0;
         vector_take <= 1'b0;
         external_trip_select <= 1'b0;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? next_rdata : svd_pkg::READ_ZERO;
         irq <= next_irq;
         wake_request <= next_wake;
         vector_take <= next_vector;
         external_trip_select <= next_ext;
      end
   end

   assign detector_power_on = ctrl.en;
   assign tap_select = ctrl.level;

   // ==========================================================
   // checker helpers
   // own count of settled cycles, so the checks do not trust settle_cnt
   localparam logic [svd_pkg::SETTLE_W-1:0] ON_FULL = svd_pkg::SETTLE_W'(STARTUP_CYCLES);
   logic [svd_pkg::SETTLE_W-1:0] on_cycles;
   wire on_saturated = on_cycles == ON_FULL;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         on_cycles <= '0;
      end else if (!ctrl.en || shared_rise) begin
         on_cycles <= '0;
      end else if (!on_saturated) begin
         on_cycles <= on_cycles + 1'b1;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   a_flag_needs_stable: assert property (
      $rose(detect_flag) |-> $past(ctrl.stable) && $past(ctrl.en))
      else $error("detect flag rose while reference unstable");

   a_rise_detect: assert property (
      ctrl.en && ctrl.stable && ctrl.dir && comp_above |=> detect_flag)
      else $error("rising crossing missed");

   a_fall_detect: assert property (
      ctrl.en && ctrl.stable && !ctrl.dir && !comp_above |=> detect_flag)
      else $error("falling crossing missed");

   a_irq_both_enables: assert property (
      irq |-> $past(detect_flag) && $past(detect_ie) && $past(global_ie))
      else $error("interrupt without both enables");

   a_off_clears_stable: assert property (
      !ctrl.en |=> !ctrl.stable)
      else $error("stable flag held with detector off");

   a_stable_waits: assert property (
      $rose(ctrl.en) |-> !ctrl.stable [*8])
      else $error("stable flag before start-up interval");

   a_sleep_wakes: assert property (
      sleep_active && detect_flag && detect_ie |=> wake_request)
      else $error("no wake on detect in sleep");

   a_vector_global: assert property (
      vector_take |-> wake_request && $past(global_ie))
      else $error("vector taken without global enable");

   a_bit6_zero: assert property (
      req && !wb_we_i && hit_ctrl |=> !wb_dat_o[6] && wb_dat_o[5] == $past(ctrl.stable))
      else $error("control readback wrong");

   a_ext_select: assert property (
      ctrl.level == svd_pkg::LEVEL_EXTERNAL |=> external_trip_select)
      else $error("external trip input not selected");

   a_ack_single: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

   a_flag_sticky: assert property (
      detect_flag && !wr_clear |=> detect_flag)
      else $error("detect flag lost without clear");

   a_set_beats_clear: assert property (
      wr_clear && detect_event |=> detect_flag)
      else $error("clear beat a simultaneous event");

   a_flag_cleared: assert property (
      wr_clear && !detect_event |=> !detect_flag)
      else $error("detect flag not cleared");

   a_off_no_event: assert property (
      !ctrl.en && !detect_flag |=> !detect_flag)
      else $error("detect flag set with detector off");

   a_irq_when_enabled: assert property (
      detect_flag && detect_ie && global_ie |=> irq)
      else $error("interrupt missing with both enables");

   a_no_wake_awake: assert property (
      !sleep_active |=> !wake_request)
      else $error("wake request while awake");

   a_vector_when_global: assert property (
      sleep_active && detect_flag && detect_ie && global_ie |=> vector_take)
      else $error("vector not taken with global enable");

   a_no_vector_local: assert property (
      !global_ie |=> !vector_take)
      else $error("vector taken without global enable");

   a_int_not_ext: assert property (
      ctrl.level != svd_pkg::LEVEL_EXTERNAL |=> !external_trip_select)
      else $error("external trip input selected for internal level");

   a_ack_follows_req: assert property (
      req |=> wb_ack_o)
      else $error("request not acknowledged");

   a_read_idle_zero: assert property (
      !wb_ack_o |-> wb_dat_o == svd_pkg::READ_ZERO)
      else $error("read data not zero outside ack");

   a_ctrl_write_lands: assert property (
      wr_ctrl |=> ctrl.dir == $past(wctrl.dir) && ctrl.en == $past(wctrl.en) && ctrl.level == $past(wctrl.level))
      else $error("control write not stored");

   a_enable_write: assert property (
      wr_en |=> detect_ie == $past(wbyte[svd_pkg::BIT_DETECT]))
      else $error("detect enable write not stored");

   a_sel_guard: assert property (
      req && wb_we_i && !wb_sel_i[0] |=> ctrl.level == $past(ctrl.level) && detect_ie == $past(detect_ie))
      else $error("write without byte select changed a register");

   a_unmapped_zero: assert property (
      req && !wb_we_i && !(hit_ctrl || hit_flags || hit_en || hit_pri || hit_int) |=> wb_dat_o == svd_pkg::READ_ZERO)
      else $error("unmapped read not zero");

   a_shared_restart: assert property (
      shared_rise |=> !ctrl.stable)
      else $error("shared reference restart kept stable flag");

   a_stable_after_count: assert property (
      ctrl.stable |-> on_cycles == ON_FULL)
      else $error("stable flag before full start-up count");

   a_stable_on_count: assert property (
      ctrl.en && !shared_rise && on_saturated |=> ctrl.stable)
      else $error("stable flag missing after start-up count");

   a_stable_needs_en: assert property (
      ctrl.stable |-> $past(ctrl.en))
      else $error("stable flag without prior enable");
endmodule : supply_voltage_detect_control
`default_nettype wire

//--- svd_pkg.sv
// Function
// - direction 1 detects rise, 0 detects fall
// - interrupt needs detect enable and global enable
// - no detect event while stable flag clear
// - stable flag only after fixed start-up interval
// - detector works in sleep, sets flag, wakes
// - wake takes vector only if globally enabled
// - reset returns all registers, detector off
// - control bits: dir 7, stable 5, enable 4
// - crossing trip point sets detect flag
// - level 1111 selects external trip input
`default_nettype none
package svd_pkg;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int STARTUP_NS = 20000;
   localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_W = 16;

   // ==========================================================
   // register map, byte addresses
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_FLAGS = 8'h04;
   localparam logic [7:0] ADDR_FLAG_CLEAR = 8'h08;
   localparam logic [7:0] ADDR_ENABLES = 8'h0c;
   localparam logic [7:0] ADDR_PRIORITY = 8'h10;
   localparam logic [7:0] ADDR_INT_CONTROL = 8'h14;

   // ==========================================================
   // field positions and values
   localparam int BIT_DETECT = 2;
   localparam int BIT_GLOBAL = 7;
   localparam int BIT_PERIPH = 6;
   localparam logic [3:0] LEVEL_EXTERNAL = 4'hf;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   typedef struct packed {
      logic dir;
      logic unused6;
      logic stable;
      logic en;
      logic [3:0] level;
   } control_t;

   localparam control_t CONTROL_RESET = '{dir: 1'b0, unused6: 1'b0, stable: 1'b0, en: 1'b0, level: 4'h0};
endpackage : svd_pkg
`default_nettype wire

//--- supply_voltage_detect_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module supply_voltage_detect_control_test;
   // ==========================================
   // stimulus and observed signals
   typedef struct packed {
      logic [7:0] adr;
      logic [7:0] wd;
      logic [7:0] rd;
   } row_t;
   logic clk_sys = 1'h0;
   logic reset_n = 1'h0;
   logic wb_cyc_i = 1'h0;
   logic wb_stb_i = 1'h0;
   logic wb_we_i = 1'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic comp_above = 1'h0;
   logic sleep_active = 1'h0;
   logic shared_ref_on = 1'h0;
   logic detector_power_on;
   logic external_trip_select;
   logic irq;
   logic wake_request;
   logic vector_take;
   logic [3:0] tap_select;
   logic [31:0] q;
   int bad_count = 0;
   int num_checks = 0;
   int cycles = 0;
   // bits 6 and 5 of control must not stick; flags and unmapped space ignore writes
   row_t rows [7] = '{'{8'h00, 8'h6a, 8'h0a}, '{8'h0c, 8'h04, 8'h04}, '{8'h10, 8'h04, 8'h04},
      '{8'h14, 8'hc0, 8'hc0}, '{8'h20, 8'hff, 8'h00}, '{8'h04, 8'hff, 8'h00}, '{8'h00, 8'h8f, 8'h8f}};

   always #5 clk_sys = ~clk_sys;

   // short start-up so the run stays brief
   supply_voltage_detect_control #(.STARTUP_CYCLES(10)) u_supply_voltage_detect_control (
      .clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .comp_above, .shared_ref_on, .detector_power_on, .tap_select,
      .external_trip_select, .sleep_active, .irq, .wake_request, .vector_take);

   // ==========================================
   // checking and bus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge clk_sys);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      // pre-edge value of ack is what this edge samples
      // only the watchdog ends a wait that never sees ack
      do begin
         @(posedge clk_sys);
      end while (wb_ack_o !== 1'h1);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      wb(a, 1'h0, 8'h00);
      chk(q, {24'h0, exp});
   endtask : rd

   task automatic results;
      $display("checks=%0d errors=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   // ==========================================
   // watchdog against a hung handshake
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         results();
      end
   end

   // ==========================================
   // main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'h1;
      rd(8'h00, 8'h00);
      foreach (rows[i]) begin
         wb(rows[i].adr, 1'h1, rows[i].wd);
         rd(rows[i].adr, rows[i].rd);
      end
      chk({31'h0, external_trip_select}, 32'h1);
      chk({31'h0, detector_power_on}, 32'h0);
      // rising detect: level, direction, then enable
      wb(8'h00, 1'h1, 8'h03);
      wb(8'h00, 1'h1, 8'h83);
      comp_above <= 1'h1;
      wb(8'h00, 1'h1, 8'h93);
      chk({28'h0, tap_select}, 32'h3);
      rd(8'h00, 8'h93);
      chk({31'h0, external_trip_select}, 32'h0);
      rd(8'h04, 8'h00);
      repeat (12) @(posedge clk_sys);
      rd(8'h00, 8'hb3);
      rd(8'h04, 8'h04);
      chk({31'h0, irq}, 32'h1);
      wb(8'h0c, 1'h1, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      wb(8'h0c, 1'h1, 8'h04);
      // a write without byte select must be ignored
      wb_sel_i <= 4'h0;
      wb(8'h0c, 1'h1, 8'h00);
      wb_sel_i <= 4'hf;
      rd(8'h0c, 8'h04);
      comp_above <= 1'h0;
      wb(8'h08, 1'h1, 8'h04);
      rd(8'h04, 8'h00);
      // falling detect after a disable, which must restart start-up
      wb(8'h00, 1'h1, 8'h03);
      rd(8'h00, 8'h03);
      wb(8'h00, 1'h1, 8'h13);
      rd(8'h04, 8'h00);
      repeat (12) @(posedge clk_sys);
      rd(8'h04, 8'h04);
      // clear while the event still holds: the set wins
      wb(8'h08, 1'h1, 8'h04);
      rd(8'h04, 8'h04);
      // another user wakes the shared reference: start-up again
      shared_ref_on <= 1'h1;
      rd(8'h00, 8'h13);
      wb(8'h08, 1'h1, 8'h04);
      rd(8'h04, 8'h00);
      repeat (12) @(posedge clk_sys);
      rd(8'h00, 8'h33);
      rd(8'h04, 8'h04);
      shared_ref_on <= 1'h0;
      // wake from sleep with and without global enable
      chk({31'h0, wake_request}, 32'h0);
      sleep_active <= 1'h1;
      repeat (3) @(posedge clk_sys);
      chk({31'h0, wake_request}, 32'h1);
      chk({31'h0, vector_take}, 32'h1);
      wb(8'h14, 1'h1, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, vector_take}, 32'h0);
      chk({31'h0, wake_request}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      // reset in mid-run
      sleep_active <= 1'h0;
      reset_n <= 1'h0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'h1;
      chk({31'h0, detector_power_on}, 32'h0);
      rd(8'h00, 8'h00);
      rd(8'h04, 8'h00);
      rd(8'h0c, 8'h00);
      results();
   end
endmodule : supply_voltage_detect_control_test
`default_nettype wire
